/* hw/rfa_defs.vh */
`ifndef RFA_DEFS_VH
`define RFA_DEFS_VH
// ----------------------------------------------------------------
// field access kinds
// ----------------------------------------------------------------
`define RFA_KIND_W           3
`define RFA_KIND_RW          3'h0
`define RFA_KIND_RO          3'h1
`define RFA_KIND_RC          3'h2
`define RFA_KIND_RWC         3'h3
`define RFA_KIND_RW1C        3'h4
`define RFA_KIND_RW1S        3'h5
`define RFA_KIND_W1C         3'h6
`define RFA_KIND_RSVD        3'h7
// ----------------------------------------------------------------
// bank layout: byte offsets relative to the bank base
// ----------------------------------------------------------------
`define RFA_OFS_W            12
`define RFA_OFS_RW           12'h000
`define RFA_OFS_RO           12'h004
`define RFA_OFS_RC           12'h008
`define RFA_OFS_RWC          12'h00c
`define RFA_OFS_RW1C         12'h010
`define RFA_OFS_RW1S         12'h014
`define RFA_OFS_W1C          12'h018
`define RFA_OFS_RSVD         12'h01c
`define RFA_NUM_REGS         8
`define RFA_RESET_VAL        32'h00000000
`define RFA_RSVD_READ        32'h00000000
`endif

/* hw/rfa_field.v */
`include "rfa_defs.vh"

// one register of the bank; KIND selects the access behaviour
module rfa_field #(
   parameter [2:0] KIND      = `RFA_KIND_RW,
   parameter       WIDTH     = 32,
   parameter [31:0] RST_VAL  = `RFA_RESET_VAL
) (
   // clock and reset
   input  wire             clk_in,
   input  wire             rst_n_in,
   // access strobes
   input  wire             sel_in,
   input  wire             wr_in,
   input  wire             rd_in,
   input  wire [WIDTH-1:0] wdata_in,
   // hardware side
   input  wire [WIDTH-1:0] hw_set_in,
   input  wire [WIDTH-1:0] hw_val_in,
   // read view
   output wire [WIDTH-1:0] rdata_out
);
   reg  [WIDTH-1:0] val_r;
   reg  [WIDTH-1:0] val_nxt;
   wire             wr_hit;
   wire             rd_hit;

   assign wr_hit = sel_in & wr_in;
   assign rd_hit = sel_in & rd_in;

   // ----------------------------------------------------------------
   // next value; hardware sets win over any clear in the same cycle
   // ----------------------------------------------------------------
   always @* begin
      val_nxt = val_r;
      case (KIND)
         `RFA_KIND_RW: begin
            if (wr_hit) begin
               val_nxt = wdata_in;
            end
         end
         `RFA_KIND_RC: begin
            if (rd_hit) begin
               val_nxt = {WIDTH{1'b0}};
            end
         end
         `RFA_KIND_RWC: begin
            if (wr_hit) begin
               val_nxt = {WIDTH{1'b0}};
            end
         end
         `RFA_KIND_RW1C, `RFA_KIND_W1C: begin
            if (wr_hit) begin
               val_nxt = val_r & ~wdata_in;
            end
         end
         `RFA_KIND_RW1S: begin
            if (wr_hit) begin
               val_nxt = val_r | wdata_in;
            end
         end
         default: begin
            val_nxt = val_r;
         end
      endcase
      if (KIND != `RFA_KIND_RW && KIND != `RFA_KIND_RO && KIND != `RFA_KIND_RSVD) begin
         val_nxt = val_nxt | hw_set_in;
      end
   end

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         val_r <= RST_VAL[WIDTH-1:0];
      end else begin
         val_r <= val_nxt;
      end
   end

   // read-only shows the live hardware value; the write-only slot shows its
   // stored bits so the block's logic can use them, and the bank hides them
   // from software reads
   assign rdata_out = (KIND == `RFA_KIND_RO)   ? hw_val_in :
                      (KIND == `RFA_KIND_RSVD) ? {WIDTH{1'b0}} :
                      val_r;
endmodule

/* hw/rfa_bank.v */
`include "rfa_defs.vh"

// ----------------------------------------------------------------
// register bank showing every field access kind
// ----------------------------------------------------------------
module rfa_bank #(
   parameter        WIDTH = 32,
   parameter [31:0] BASE  = 32'h00000000
) (
   // clock and reset
   input  wire             clk_sys_in,
   input  wire             resetn_in,
   // access port
   input  wire             sel_in,
   input  wire             wr_in,
   input  wire             rd_in,
   input  wire [31:0]      addr_in,
   input  wire [WIDTH-1:0] wdata_in,
   output reg  [WIDTH-1:0] rdata_out,
   output reg              hit_out,
   // hardware events and status
   input  wire [WIDTH-1:0] ro_val_in,
   input  wire [WIDTH-1:0] rc_set_in,
   input  wire [WIDTH-1:0] rwc_set_in,
   input  wire [WIDTH-1:0] rw1c_set_in,
   input  wire [WIDTH-1:0] rw1s_set_in,
   input  wire [WIDTH-1:0] w1c_set_in,
   // stored values to the block's logic
   output wire [WIDTH-1:0] ctrl_out,
   output wire [WIDTH-1:0] rw1c_val_out,
   output wire [WIDTH-1:0] rw1s_val_out,
   output wire [WIDTH-1:0] w1c_val_out
);
   reg              rst_meta_r;
   reg              rst_sync_r;
   wire [WIDTH-1:0] rd_vec [0:`RFA_NUM_REGS-1];
   wire [WIDTH-1:0] set_vec [0:`RFA_NUM_REGS-1];
   wire [WIDTH-1:0] zero_w;
   wire             in_bank;
   wire [`RFA_OFS_W-1:0] ofs;
   wire [2:0]       idx;
   wire             wr_acc;
   wire             rd_acc;
   wire [`RFA_NUM_REGS-1:0] slot_sel;
   reg  [WIDTH-1:0] rd_sel;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------

   // index of a register from its byte offset
   function [2:0] reg_index;
      input [`RFA_OFS_W-1:0] o;
      begin
         reg_index = o[4:2];
      end
   endfunction

   // access kind of each slot; shared by the field instances and the read path
   function [2:0] slot_kind;
      input [31:0] s;
      begin
         case (s)
            32'h0:   slot_kind = `RFA_KIND_RW;
            32'h1:   slot_kind = `RFA_KIND_RO;
            32'h2:   slot_kind = `RFA_KIND_RC;
            32'h3:   slot_kind = `RFA_KIND_RWC;
            32'h4:   slot_kind = `RFA_KIND_RW1C;
            32'h5:   slot_kind = `RFA_KIND_RW1S;
            32'h6:   slot_kind = `RFA_KIND_W1C;
            default: slot_kind = `RFA_KIND_RSVD;
         endcase
      end
   endfunction

   // write-only reads carry no meaning; returning zero keeps pending
   // status from leaking to software through a stray read
   function slot_readable;
      input [2:0] k;
      begin
         case (k)
            `RFA_KIND_W1C:  slot_readable = 1'b0;
            `RFA_KIND_RSVD: slot_readable = 1'b0;
            default:        slot_readable = 1'b1;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // address decode: base plus aligned byte offset
   // ----------------------------------------------------------------
   assign ofs     = addr_in[`RFA_OFS_W-1:0];
   assign in_bank = (addr_in[31:`RFA_OFS_W] == BASE[31:`RFA_OFS_W]) &&
                    (ofs[1:0] == 2'h0) && (ofs <= `RFA_OFS_RSVD);
   assign idx     = reg_index(ofs);
   assign zero_w  = {WIDTH{1'b0}};

   // ----------------------------------------------------------------
   // access qualifiers; a write wins when both strobes are high
   // ----------------------------------------------------------------
   assign wr_acc = sel_in & wr_in;
   assign rd_acc = sel_in & rd_in & ~wr_in;

   assign set_vec[0] = zero_w;
   assign set_vec[1] = zero_w;
   assign set_vec[2] = rc_set_in;
   assign set_vec[3] = rwc_set_in;
   assign set_vec[4] = rw1c_set_in;
   assign set_vec[5] = rw1s_set_in;
   assign set_vec[6] = w1c_set_in;
   assign set_vec[7] = zero_w;

   // ----------------------------------------------------------------
   // one field instance per slot
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `RFA_NUM_REGS; g = g + 1) begin : slot
         localparam [2:0] K = slot_kind(g);
         assign slot_sel[g] = in_bank && (idx == g);
         rfa_field #(
            .KIND    (K),
            .WIDTH   (WIDTH),
            .RST_VAL (`RFA_RESET_VAL)
         ) u_fld (
            .clk_in    (clk_sys_in),
            .rst_n_in  (rst_sync_r),
            .sel_in    (slot_sel[g]),
            .wr_in     (wr_acc),
            .rd_in     (rd_acc),
            .wdata_in  (wdata_in),
            .hw_set_in (set_vec[g]),
            .hw_val_in (ro_val_in),
            .rdata_out (rd_vec[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // registered read data; the clear-on-read slot updates on the same
   // edge, so the read returns the value before clearing
   // ----------------------------------------------------------------
   always @* begin
      rd_sel = zero_w;
      if (in_bank && slot_readable(slot_kind({29'h0, idx}))) begin
         rd_sel = rd_vec[idx];
      end
   end

   always @(posedge clk_sys_in or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         rdata_out <= zero_w;
      end else if (rd_acc) begin
         rdata_out <= rd_sel;
      end
   end

   // ----------------------------------------------------------------
   // hit flag: one cycle, mapped and aligned accesses only
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         hit_out <= 1'b0;
      end else begin
         hit_out <= sel_in & in_bank;
      end
   end

   // ----------------------------------------------------------------
   // stored values to the block's logic; the write-only slot is
   // visible here although software reads of it return zero
   // ----------------------------------------------------------------
   assign ctrl_out     = rd_vec[0];
   assign rw1c_val_out = rd_vec[4];
   assign rw1s_val_out = rd_vec[5];
   assign w1c_val_out  = rd_vec[6];
endmodule

/* verification/rfa_bank_props.sv */
`include "rfa_defs.vh"

module rfa_bank_props #(
   parameter        WIDTH = 32,
   parameter [31:0] BASE  = 32'h00000000
) (
   // clock, reset and access
   input wire             clk_sys_in,
   input wire             resetn_in,
   input wire             sel_in,
   input wire             wr_in,
   input wire             rd_in,
   input wire [31:0]      addr_in,
   input wire [WIDTH-1:0] wdata_in,
   input wire [WIDTH-1:0] rdata_out,
   input wire             hit_out,
   // events and stored values
   input wire [WIDTH-1:0] rc_set_in,
   input wire [WIDTH-1:0] rwc_set_in,
   input wire [WIDTH-1:0] rw1c_set_in,
   input wire [WIDTH-1:0] rw1s_set_in,
   input wire [WIDTH-1:0] w1c_set_in,
   input wire [WIDTH-1:0] rw1c_val_out,
   input wire [WIDTH-1:0] rw1s_val_out,
   input wire [WIDTH-1:0] w1c_val_out
);
   timeunit 1ns;
   timeprecision 100ps;
   wire [11:0] ofs = addr_in[11:0];
   wire        acc = sel_in && addr_in[31:12] == BASE[31:12] && ofs[1:0] == 2'h0 && ofs <= `RFA_OFS_RSVD;
   wire        wr  = acc && wr_in;
   wire        rd  = acc && !wr_in && rd_in;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   sequence s_rc_read;
      rd && ofs == `RFA_OFS_RC;
   endsequence
   sequence s_rwc_write;
      wr && ofs == `RFA_OFS_RWC;
   endsequence
   sequence s_rwc_read;
      rd && ofs == `RFA_OFS_RWC;
   endsequence
   // ----------------------------------------------------------------
   // decode, field behaviour
   // ----------------------------------------------------------------
   a_hit_mapped: assert property (acc |=> hit_out) else $error("mapped access gave no hit");
   a_hit_unmapped: assert property (sel_in && !acc |=> !hit_out) else $error("unmapped access hit");
   a_rc_clears: assert property (s_rc_read ##1 s_rc_read |=> rdata_out == $past(rc_set_in, 2))
      else $error("clear-on-read value not cleared");
   a_rwc_clears: assert property (s_rwc_write ##1 s_rwc_read |=> rdata_out == $past(rwc_set_in, 2))
      else $error("clear-on-write value not cleared");
   a_rw1c_write: assert property (wr && ofs == `RFA_OFS_RW1C |=>
      rw1c_val_out == (($past(rw1c_val_out) & ~$past(wdata_in)) | $past(rw1c_set_in))) else $error("rw1c write wrong");
   a_rw1c_read: assert property (rd && ofs == `RFA_OFS_RW1C |=> rdata_out == $past(rw1c_val_out))
      else $error("rw1c read wrong");
   a_rw1s_write: assert property (wr && ofs == `RFA_OFS_RW1S |=>
      rw1s_val_out == ($past(rw1s_val_out) | $past(wdata_in) | $past(rw1s_set_in))) else $error("rw1s write wrong");
   a_rw1s_hold: assert property (1'b1 |=> (rw1s_val_out & $past(rw1s_val_out)) == $past(rw1s_val_out))
      else $error("set bit lost");
   a_w1c_write: assert property (wr && ofs == `RFA_OFS_W1C |=>
      w1c_val_out == (($past(w1c_val_out) & ~$past(wdata_in)) | $past(w1c_set_in))) else $error("w1c write wrong");
   a_rsvd_zero: assert property (rd && ofs == `RFA_OFS_RSVD |=> rdata_out == `RFA_RSVD_READ)
      else $error("reserved read not zero");
endmodule

bind rfa_bank rfa_bank_props #(.WIDTH(WIDTH), .BASE(BASE)) u_props (
   .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .sel_in(sel_in), .wr_in(wr_in), .rd_in(rd_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .hit_out(hit_out), .rc_set_in(rc_set_in),
   .rwc_set_in(rwc_set_in),
   .rw1c_set_in(rw1c_set_in), .rw1s_set_in(rw1s_set_in), .w1c_set_in(w1c_set_in),
   .rw1c_val_out(rw1c_val_out), .rw1s_val_out(rw1s_val_out), .w1c_val_out(w1c_val_out));

/* verification/tb_rfa_bank.sv */
`include "rfa_defs.vh"

module tb_rfa_bank;
   timeunit 1ns;
   timeprecision 100ps;
   // bank placed off zero so the upper address decode is exercised
   localparam [31:0] B = 32'h40001000;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        sel = 1'b0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] addr = 32'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] ro = 32'h5a3c0081;
   logic [31:0] st [5] = '{default: 32'h0};
   logic [31:0] rdat, ctrl, v1c, v1s, vw1c;
   logic        hit;
   int          fails = 0;
   int          n_tests = 0;
   int          cyc = 0;
   rfa_bank #(.WIDTH(32), .BASE(B)) dut_u (
      .clk_sys_in(clk), .resetn_in(rst_n), .sel_in(sel), .wr_in(wr), .rd_in(rd), .addr_in(addr),
      .wdata_in(wdat), .rdata_out(rdat), .hit_out(hit), .ro_val_in(ro), .rc_set_in(st[0]), .rwc_set_in(st[1]),
      .rw1c_set_in(st[2]), .rw1s_set_in(st[3]), .w1c_set_in(st[4]), .ctrl_out(ctrl), .rw1c_val_out(v1c),
      .rw1s_val_out(v1s), .w1c_val_out(vw1c));
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         test_done;
      end
   end
   task test_done;
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
         fails++;
      end
   endtask
   // ----------------------------------------------------------------
   // one access, held across its taking edge; result readable after
   // ----------------------------------------------------------------
   task acc(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      sel <= 1'b1;
      wr <= w;
      rd <= !w;
      addr <= a;
      wdat <= d;
      @(posedge clk);
      sel <= 1'b0;
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask
   task pulse(input int i, input logic [31:0] v);
      @(posedge clk);
      st[i] <= v;
      @(posedge clk);
      st[i] <= 32'h0;
      #1;
   endtask
   // two accesses on consecutive edges, no idle cycle between them
   task pair(input logic w0, input logic [31:0] a0, input logic [31:0] d, input logic w1, input logic [31:0] a1);
      @(posedge clk);
      sel <= 1'b1;
      wr <= w0;
      rd <= !w0;
      addr <= a0;
      wdat <= d;
      @(posedge clk);
      wr <= w1;
      rd <= !w1;
      addr <= a1;
      @(posedge clk);
      sel <= 1'b0;
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask
   task t_rw_ro;
      acc(1'b1, B, 32'ha5a5c3c3);
      chk(ctrl, 32'ha5a5c3c3);
      acc(1'b0, B, 32'h0);
      acc(1'b1, B, (rdat & 32'hffff0000) | 32'h0000beef);
      chk(ctrl, 32'ha5a5beef);
      acc(1'b1, B + 32'h2, 32'hffffffff);
      chk(ctrl, 32'ha5a5beef);
      acc(1'b1, B + `RFA_OFS_RO, `RFA_RESET_VAL);
      acc(1'b0, B + `RFA_OFS_RO, 32'h0);
      chk(rdat, ro);
      chk({31'h0, hit}, 32'h1);
   endtask
   task t_rc_rwc;
      pulse(0, 32'h0000000f);
      acc(1'b0, B + `RFA_OFS_RC, 32'h0);
      chk(rdat, 32'h0000000f);
      acc(1'b0, B + `RFA_OFS_RC, 32'h0);
      chk(rdat, 32'h0);
      pulse(0, 32'h00000005);
      pair(1'b0, B + `RFA_OFS_RC, 32'h0, 1'b0, B + `RFA_OFS_RC);
      chk(rdat, 32'h0);
      pulse(1, 32'h000000f0);
      acc(1'b0, B + `RFA_OFS_RWC, 32'h0);
      chk(rdat, 32'h000000f0);
      acc(1'b1, B + `RFA_OFS_RWC, 32'h0000000f);
      acc(1'b0, B + `RFA_OFS_RWC, 32'h0);
      chk(rdat, 32'h0);
      pulse(1, 32'h00000a00);
      pair(1'b1, B + `RFA_OFS_RWC, 32'h0000000f, 1'b0, B + `RFA_OFS_RWC);
      chk(rdat, 32'h0);
   endtask
   task t_w1c;
      pulse(2, 32'h000000ff);
      acc(1'b1, B + `RFA_OFS_RW1C, 32'h0000000f);
      acc(1'b0, B + `RFA_OFS_RW1C, 32'h0);
      chk(rdat, 32'h000000f0);
      acc(1'b1, B + `RFA_OFS_RW1C, rdat);
      chk(v1c, 32'h0);
      pulse(4, 32'h0000003c);
      acc(1'b1, B + `RFA_OFS_W1C, 32'h0000000c);
      chk(vw1c, 32'h00000030);
   endtask
   task t_w1s;
      acc(1'b1, B + `RFA_OFS_RW1S, 32'h00000011);
      pulse(3, 32'h00000100);
      acc(1'b1, B + `RFA_OFS_RW1S, 32'h0);
      acc(1'b0, B + `RFA_OFS_RW1S, 32'h0);
      chk(rdat, 32'h00000111);
      chk(v1s, 32'h00000111);
   endtask
   // mid-run reset: set bits go, and the bank takes accesses again after release
   task t_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      #1;
      chk(v1s, `RFA_RESET_VAL);
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      acc(1'b1, B, 32'h00000003);
      chk(ctrl, 32'h00000003);
   endtask
   task t_map;
      acc(1'b0, B + `RFA_OFS_RSVD, 32'h0);
      chk(rdat, 32'h0);
      acc(1'b0, B + 32'h2, 32'h0);
      chk({31'h0, hit}, 32'h0);
      acc(1'b0, B + 32'h1000, 32'h0);
      chk({31'h0, hit}, 32'h0);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_rw_ro;
      t_rc_rwc;
      t_w1c;
      t_w1s;
      t_reset;
      t_map;
      test_done;
   end
endmodule
